// [hdl/scr_relay.sv]
// Result store, channel sequencer, serial result read-out, stack relay,
// fault qualification and self-timed OTP write pulse of one cell monitor.
// Assumes sys_clk at 100 MHz; the host serial clock clocks the read-out
// and may stop between frames; converter and comparators share sys_clk.
`include "scr_cfg.svh"
`default_nettype none
module scr_relay #(
   parameter int FAULT_STEP_CYCLES = `SCR_FAULT_STEP_CYCLES,
   parameter int OTP_PULSE_CYCLES = `SCR_OTP_PULSE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic stack_strap,
   input wire logic host_port_sclk,
   input wire logic host_port_cs_b,
   input wire logic host_port_serial_in,
   input wire logic host_port_convert_start,
   output logic host_port_serial_out,
   output logic host_port_serial_out_oe,
   output logic host_port_data_ready,
   output logic host_port_fault,
   output logic host_port_alert,
   input wire logic south_port_sclk,
   input wire logic south_port_cs_b,
   input wire logic south_port_serial_in,
   input wire logic south_port_convert_start,
   output logic south_port_serial_out,
   output logic south_port_data_ready,
   output logic south_port_fault,
   output logic south_port_alert,
   output logic north_port_sclk,
   output logic north_port_cs_b,
   output logic north_port_serial_in,
   output logic north_port_convert_start,
   input wire logic north_port_serial_out,
   input wire logic north_port_data_ready,
   input wire logic north_port_fault,
   input wire logic north_port_alert,
   input wire logic conv_req,
   input wire logic general_analog_input_src,
   output logic [3:0] adc_mux_sel,
   output logic adc_general_analog_input_path,
   output logic adc_sample,
   output logic conv_busy,
   input wire logic adc_done,
   input wire logic signed [15:0] adc_raw,
   input wire logic fault_in,
   input wire logic [4:0] fault_delay_steps,
   output logic fault_qualified,
   input wire logic otp_write_req,
   output logic otp_busy
);
   // Pin synchronisers and stack relay
   logic [3:0] dn_host_s1_q, dn_host_s2_q, dn_south_s1_q, dn_south_s2_q;
   logic [3:0] up_north_s1_q, up_north_s2_q, north_q, host_up_q, south_up_q;
   logic strap_s1_q, strap_s2_q, strap_q, strap_valid_q;
   logic [1:0] strap_wait_q;
   logic own_bit_s1_q, own_bit_s2_q, own_act_s1_q, own_act_s2_q, sdo_oe_q;
   logic own_bit, own_act;
   logic [3:0] dn_host_in, dn_south_in, up_north_in;

   assign dn_host_in = {host_port_convert_start, host_port_serial_in, host_port_cs_b,
                        host_port_sclk};
   assign dn_south_in = {south_port_convert_start, south_port_serial_in, south_port_cs_b,
                         south_port_sclk};
   assign up_north_in = {north_port_alert, north_port_fault, north_port_data_ready,
                         north_port_serial_out};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dn_host_s1_q <= 4'h2;
         dn_host_s2_q <= 4'h2;
         dn_south_s1_q <= 4'h2;
         dn_south_s2_q <= 4'h2;
         up_north_s1_q <= 4'h0;
         up_north_s2_q <= 4'h0;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
         own_bit_s1_q <= 1'b0;
         own_bit_s2_q <= 1'b0;
         own_act_s1_q <= 1'b0;
         own_act_s2_q <= 1'b0;
      end else begin
         dn_host_s1_q <= dn_host_in;
         dn_host_s2_q <= dn_host_s1_q;
         dn_south_s1_q <= dn_south_in;
         dn_south_s2_q <= dn_south_s1_q;
         up_north_s1_q <= up_north_in;
         up_north_s2_q <= up_north_s1_q;
         strap_s1_q <= stack_strap;
         strap_s2_q <= strap_s1_q;
         own_bit_s1_q <= own_bit;
         own_bit_s2_q <= own_bit_s1_q;
         own_act_s1_q <= own_act;
         own_act_s2_q <= own_act_s1_q;
      end
   end

   // Strap is caught once, after the synchroniser has filled
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_wait_q <= 2'h0;
         strap_q <= 1'b0;
         strap_valid_q <= 1'b0;
      end else if (strap_wait_q != 2'h2) begin
         strap_wait_q <= strap_wait_q + 2'h1;
      end else if (!strap_valid_q) begin
         strap_q <= strap_s2_q;
         strap_valid_q <= 1'b1;
      end
   end

   // Downward and upward relay, one lane per signal
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               north_q[gi] <= (gi == `SCR_RELAY_CS);
               host_up_q[gi] <= 1'b0;
               south_up_q[gi] <= 1'b0;
            end else begin
               north_q[gi] <= strap_q ? dn_south_s2_q[gi] : dn_host_s2_q[gi];
               host_up_q[gi] <= strap_q ? 1'b0 : up_north_s2_q[gi];
               south_up_q[gi] <= strap_q ? up_north_s2_q[gi] : 1'b0;
            end
         end
      end
   endgenerate

   // Own read-out bits take over host serial out during the data phase
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sdo_oe_q <= 1'b0;
      end else begin
         sdo_oe_q <= !strap_q && !dn_host_s2_q[`SCR_RELAY_CS];
      end
   end

   assign north_port_sclk = north_q[`SCR_RELAY_SCLK];
   assign north_port_cs_b = north_q[`SCR_RELAY_CS];
   assign north_port_serial_in = north_q[`SCR_RELAY_SDI];
   assign north_port_convert_start = north_q[`SCR_RELAY_CONV];
   logic host_sdo_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_sdo_q <= 1'b0;
      end else begin
         host_sdo_q <= own_act_s2_q ? own_bit_s2_q : host_up_q[`SCR_RET_SDO];
      end
   end
   assign host_port_serial_out = host_sdo_q;
   assign host_port_serial_out_oe = sdo_oe_q;
   assign host_port_data_ready = host_up_q[`SCR_RET_DRDY];
   assign host_port_fault = host_up_q[`SCR_RET_FAULT];
   assign host_port_alert = host_up_q[`SCR_RET_ALERT];
   assign south_port_serial_out = south_up_q[`SCR_RET_SDO];
   assign south_port_data_ready = south_up_q[`SCR_RET_DRDY];
   assign south_port_fault = south_up_q[`SCR_RET_FAULT];
   assign south_port_alert = south_up_q[`SCR_RET_ALERT];

   // Channel sequencer and result store
   scr_pkg::scr_seq_e state_q;
   logic [3:0] ch_q, mux_sel_q;
   logic general_analog_input_path_q, sample_q;
   scr_pkg::scr_result_t result_q [`SCR_NUM_CH];
   scr_pkg::scr_result_t shadow_q [`SCR_NUM_CH];
   logic store_en;

   function automatic scr_pkg::scr_result_t scr_clamp(input logic signed [15:0] raw);
      if (raw < 16'sh0000) begin
         scr_clamp = 14'h0000;
      end else if (raw > `SCR_RES_MAX) begin
         scr_clamp = 14'h3fff;
      end else begin
         scr_clamp = raw[13:0];
      end
   endfunction

   assign store_en = (state_q == scr_pkg::SCR_WAIT) && adc_done;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= scr_pkg::SCR_IDLE;
         ch_q <= 4'h0;
         mux_sel_q <= 4'h0;
         general_analog_input_path_q <= 1'b0;
         sample_q <= 1'b0;
      end else begin
         sample_q <= 1'b0;
         unique case (state_q)
            scr_pkg::SCR_IDLE: begin
               if (conv_req) begin
                  ch_q <= `SCR_GENERAL_ANALOG_INPUT_CH;
                  mux_sel_q <= `SCR_GENERAL_ANALOG_INPUT_CH;
                  general_analog_input_path_q <= general_analog_input_src;
                  sample_q <= 1'b1;
                  state_q <= scr_pkg::SCR_SAMPLE;
               end
            end
            scr_pkg::SCR_SAMPLE: begin
               state_q <= scr_pkg::SCR_WAIT;
            end
            scr_pkg::SCR_WAIT: begin
               if (adc_done) begin
                  if (ch_q == `SCR_LAST_CH) begin
                     state_q <= scr_pkg::SCR_IDLE;
                  end else begin
                     ch_q <= ch_q + 4'h1;
                     mux_sel_q <= ch_q + 4'h1;
                     sample_q <= 1'b1;
                     state_q <= scr_pkg::SCR_SAMPLE;
                  end
               end
            end
            default: begin
               state_q <= scr_pkg::SCR_IDLE;
            end
         endcase
      end
   end

   generate
      for (gi = 0; gi < `SCR_NUM_CH; gi++) begin : g_res
         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               result_q[gi] <= 14'h0000;
               shadow_q[gi] <= 14'h0000;
            end else begin
               if (store_en && ch_q == gi) begin
                  result_q[gi] <= scr_clamp(adc_raw);
               end
               // Read-out copy frozen while a host frame is open
               if (dn_host_s2_q[`SCR_RELAY_CS]) begin
                  shadow_q[gi] <= result_q[gi];
               end
            end
         end
      end
   endgenerate

   assign adc_mux_sel = mux_sel_q;
   assign adc_general_analog_input_path = general_analog_input_path_q;
   assign adc_sample = sample_q;
   assign conv_busy = (state_q != scr_pkg::SCR_IDLE);

   // Byte view of the result words
   function automatic logic [7:0] scr_reg_byte(input logic [7:0] addr,
                                               input scr_pkg::scr_result_t w);
      scr_reg_byte = addr[0] ? {2'b00, w[13:8]} : w[7:0];
   endfunction

   // Host serial read-out, link clock domain; chip select high ends the frame
   logic link_rst_b, data_ph_q, own_bit_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] addr_q, tx_q, next_addr, rd_byte;
   logic [3:0] rd_ch;
   assign link_rst_b = rst_b && !host_port_cs_b;
   assign next_addr = data_ph_q ? addr_q + 8'h01 : {addr_q[6:0], host_port_serial_in};
   assign rd_ch = 4'((next_addr - `SCR_FIRST_RES_ADDR) >> 1);
   always_comb begin
      rd_byte = 8'h00;
      if (next_addr >= `SCR_FIRST_RES_ADDR && next_addr <= `SCR_LAST_RES_ADDR) begin
         rd_byte = scr_reg_byte(next_addr, shadow_q[rd_ch]);
      end
   end
   always_ff @(posedge host_port_sclk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt_q <= 3'h0;
         addr_q <= 8'h00;
         tx_q <= 8'h00;
         data_ph_q <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         tx_q <= {tx_q[6:0], 1'b0};
         if (!data_ph_q) begin
            addr_q <= next_addr;
         end
         if (bit_cnt_q == 3'h7) begin
            tx_q <= rd_byte;
            data_ph_q <= 1'b1;
            if (data_ph_q) begin
               addr_q <= next_addr;
            end
         end
      end
   end
   assign own_bit = tx_q[7];
   assign own_act = data_ph_q;

   // Fault qualification on a shared step tick
   logic [31:0] step_cnt_q;
   logic [4:0] fault_cnt_q;
   logic fault_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt_q <= 32'h0;
         fault_cnt_q <= 5'h00;
         fault_q <= 1'b0;
      end else begin
         step_cnt_q <= (step_cnt_q == 32'(FAULT_STEP_CYCLES - 1)) ? 32'h0 : step_cnt_q + 32'h1;
         if (!fault_in) begin
            fault_cnt_q <= 5'h00;
            fault_q <= 1'b0;
         end else if (fault_cnt_q >= fault_delay_steps) begin
            fault_q <= 1'b1;
         end else if (step_cnt_q == 32'h0) begin
            fault_cnt_q <= fault_cnt_q + 5'h01;
         end
      end
   end
   assign fault_qualified = fault_q;

   // Self-timed OTP write pulse
   logic [31:0] otp_cnt_q;
   logic otp_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         otp_cnt_q <= 32'h0;
         otp_q <= 1'b0;
      end else if (otp_q) begin
         otp_cnt_q <= otp_cnt_q + 32'h1;
         if (otp_cnt_q == 32'(OTP_PULSE_CYCLES - 1)) begin
            otp_q <= 1'b0;
         end
      end else if (otp_write_req) begin
         otp_cnt_q <= 32'h0;
         otp_q <= 1'b1;
      end
   end
   assign otp_busy = otp_q;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_result_floor: assert property (store_en && adc_raw < 16'sh0000 |=>
      result_q[$past(ch_q)] == 14'h0000) else $error("negative result not clamped");
   a_result_ceiling: assert property (store_en && adc_raw > `SCR_RES_MAX |=>
      result_q[$past(ch_q)] == 14'h3fff) else $error("overrange result not clamped");
   a_result_hold: assert property (!(store_en && ch_q == 4'h1) |=>
      $stable(result_q[1])) else $error("cell one result changed without conversion");
   a_cell_pair_map: assert property (next_addr == `SCR_CELL1_HI_ADDR |->
      rd_byte == {2'b00, shadow_q[1][13:8]}) else $error("cell one upper byte mismatch");
   a_cell_low_byte: assert property (next_addr == `SCR_CELL1_LO_ADDR |->
      rd_byte == shadow_q[1][7:0]) else $error("cell one lower byte mismatch");
   a_mux_range: assert property ($rose(sample_q) |-> mux_sel_q <= `SCR_LAST_CH &&
      mux_sel_q == ch_q ##1 state_q == scr_pkg::SCR_WAIT) else $error("bad selector");
   a_general_analog_input_path: assert property (sample_q && mux_sel_q == `SCR_GENERAL_ANALOG_INPUT_CH |->
      general_analog_input_path_q == $past(general_analog_input_src)) else $error("general input path not taken");
   a_sdo_release: assert property (dn_host_s2_q[`SCR_RELAY_CS] |=>
      !host_port_serial_out_oe) else $error("serial out driven with chip select high");
   a_relay_host: assert property (strap_valid_q && !strap_q |=>
      north_q == $past(dn_host_s2_q)) else $error("host inputs not relayed north");
   a_relay_south: assert property (strap_valid_q && strap_q |=>
      north_q == $past(dn_south_s2_q)) else $error("south inputs not relayed north");
   a_relay_return: assert property (strap_valid_q && $stable(strap_q) |=>
      (strap_q ? south_up_q : host_up_q) == $past(up_north_s2_q))
      else $error("north return misrouted");
   a_fault_qual: assert property ($rose(fault_q) |-> $past(fault_in) &&
      $past(fault_cnt_q) >= $past(fault_delay_steps)) else $error("fault qualified early");
   a_otp_pulse: assert property ($rose(otp_q) |-> otp_cnt_q == 32'h0 ##1 otp_q[*8])
      else $error("otp pulse cut short");
   a_otp_end: assert property (otp_q && otp_cnt_q == 32'(OTP_PULSE_CYCLES - 1) |=>
      !otp_q) else $error("otp pulse overran");

   c_full_scan: cover property (store_en && ch_q == `SCR_LAST_CH);
   c_south_relay: cover property (strap_q && $rose(north_port_cs_b));
   c_otp_done: cover property ($fell(otp_q));
   c_fault_hit: cover property ($rose(fault_q));
endmodule
`default_nettype wire

// [hdl/scr_cfg.svh]
// Constants for the cell result relay: register addresses, field
// positions, widths and timing figures with their derived cycle counts.
// Assumes a 100 MHz system clock.
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define SCR_CLK_MHZ 100
`define SCR_RES_W 14
`define SCR_RES_MAX 16'sh3fff
`define SCR_NUM_CH 9
`define SCR_CH_W 4
`define SCR_GENERAL_ANALOG_INPUT_CH 4'h0
`define SCR_LAST_CH 4'h8
`define SCR_FIRST_RES_ADDR 8'h01
`define SCR_LAST_RES_ADDR 8'h12
`define SCR_CELL1_HI_ADDR 8'h03
`define SCR_CELL1_LO_ADDR 8'h04
`define SCR_RELAY_SCLK 0
`define SCR_RELAY_CS 1
`define SCR_RELAY_SDI 2
`define SCR_RELAY_CONV 3
`define SCR_RET_SDO 0
`define SCR_RET_DRDY 1
`define SCR_RET_FAULT 2
`define SCR_RET_ALERT 3
`define SCR_FAULT_STEP_US 100
`define SCR_FAULT_STEP_CYCLES (`SCR_FAULT_STEP_US * `SCR_CLK_MHZ)
`define SCR_OTP_PULSE_MS 50
`define SCR_OTP_PULSE_CYCLES (`SCR_OTP_PULSE_MS * 1000 * `SCR_CLK_MHZ)

`endif

// [hdl/scr_pkg.sv]
// Types for the cell result relay.
// Assumes scr_cfg.svh supplies all numeric constants.
`default_nettype none
package scr_pkg;
   typedef enum logic [1:0] {
      SCR_IDLE = 2'b00,
      SCR_SAMPLE = 2'b01,
      SCR_WAIT = 2'b10
   } scr_seq_e;
   typedef logic [13:0] scr_result_t;
endpackage
`default_nettype wire

// [bench/scr_north_model.sv]
// Behavioural model of the monitor stacked above: drives the north return lines.
// Assumes the bench sets want on the system clock; outputs lag want by one cycle.
`default_nettype none
module scr_north_model (
   input wire logic sys_clk,
   input wire logic sel_b,
   input wire logic [3:0] want,
   output logic serial_out,
   output logic data_ready,
   output logic fault,
   output logic alert
);
   timeunit 1ns;
   timeprecision 100ps;
   logic spin_q = 1'b0;

   // Released data line shows a changing pattern, never a held value
   always_ff @(posedge sys_clk) begin
      spin_q <= ~spin_q;
      serial_out <= sel_b ? spin_q : want[3];
      {data_ready, fault, alert} <= want[2:0];
   end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the cell result relay with the upper monitor modelled.
// Assumes shortened fault step and write pulse counts set at the instance.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] PATS = 16'h96a5;
   logic sys_clk, rst_b, stack_strap;
   logic host_port_sclk, host_port_cs_b, host_port_serial_in, host_port_convert_start;
   logic host_port_serial_out, host_port_serial_out_oe, host_port_data_ready;
   logic host_port_fault, host_port_alert;
   logic south_port_sclk, south_port_cs_b, south_port_serial_in, south_port_convert_start;
   logic south_port_serial_out, south_port_data_ready, south_port_fault, south_port_alert;
   logic north_port_sclk, north_port_cs_b, north_port_serial_in, north_port_convert_start;
   logic north_port_serial_out, north_port_data_ready, north_port_fault, north_port_alert;
   logic conv_req, general_analog_input_src, adc_general_analog_input_path, adc_sample, conv_busy, adc_done;
   logic fault_in, fault_qualified, otp_write_req, otp_busy;
   logic [3:0] adc_mux_sel, model_want;
   logic [4:0] fault_delay_steps;
   logic signed [15:0] adc_raw;
   logic signed [15:0] raw_v [9];
   logic [31:0] d;
   int error_cnt = 0;
   int tests_run = 0;

   scr_relay #(.FAULT_STEP_CYCLES(8), .OTP_PULSE_CYCLES(20)) u_scr_relay (
      .sys_clk, .rst_b, .stack_strap, .host_port_sclk, .host_port_cs_b,
      .host_port_serial_in, .host_port_convert_start, .host_port_serial_out,
      .host_port_serial_out_oe, .host_port_data_ready, .host_port_fault, .host_port_alert,
      .south_port_sclk, .south_port_cs_b, .south_port_serial_in, .south_port_convert_start,
      .south_port_serial_out, .south_port_data_ready, .south_port_fault, .south_port_alert,
      .north_port_sclk, .north_port_cs_b, .north_port_serial_in, .north_port_convert_start,
      .north_port_serial_out, .north_port_data_ready, .north_port_fault, .north_port_alert,
      .conv_req, .general_analog_input_src, .adc_mux_sel, .adc_general_analog_input_path, .adc_sample, .conv_busy,
      .adc_done, .adc_raw, .fault_in, .fault_delay_steps, .fault_qualified,
      .otp_write_req, .otp_busy
   );

   scr_north_model u_scr_north_model (
      .sys_clk(sys_clk), .sel_b(north_port_cs_b), .want(model_want),
      .serial_out(north_port_serial_out), .data_ready(north_port_data_ready),
      .fault(north_port_fault), .alert(north_port_alert)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset(input logic strap);
      @(posedge sys_clk);
      #1 rst_b = 1'b0;
      stack_strap = strap;
      repeat (3) @(posedge sys_clk);
      #1 check("oe_in_reset", host_port_serial_out_oe, 1'b0);
      check("north_cs_in_reset", north_port_cs_b, 1'b1);
      rst_b = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask

   task automatic relay_chk(input logic strap);
      logic [3:0] p;
      for (int k = 0; k < 4; k++) begin
         p = PATS[4*k +: 4];
         {host_port_sclk, host_port_cs_b, host_port_serial_in, host_port_convert_start} =
            strap ? ~p : p;
         {south_port_sclk, south_port_cs_b, south_port_serial_in, south_port_convert_start} =
            strap ? p : ~p;
         repeat (4) @(posedge sys_clk);
         #1 check("north_fwd", {north_port_sclk, north_port_cs_b, north_port_serial_in,
            north_port_convert_start}, p);
         #3000;
      end
      {host_port_sclk, host_port_cs_b, host_port_serial_in, host_port_convert_start} = 4'h0;
      {south_port_sclk, south_port_cs_b, south_port_serial_in, south_port_convert_start} = 4'h0;
      for (int k = 0; k < 4; k++) begin
         model_want = PATS[4*k +: 4];
         repeat (6) @(posedge sys_clk);
         #1 check("host_oe", host_port_serial_out_oe, !strap);
         check("host_ret", {host_port_data_ready, host_port_fault, host_port_alert},
            strap ? 3'h0 : model_want[2:0]);
         if (!strap) check("host_sdo", host_port_serial_out, model_want[3]);
         check("south_ret", {south_port_serial_out, south_port_data_ready, south_port_fault,
            south_port_alert}, strap ? model_want : 4'h0);
      end
      {host_port_sclk, host_port_cs_b, host_port_serial_in, host_port_convert_start} = 4'h4;
      {south_port_sclk, south_port_cs_b, south_port_serial_in, south_port_convert_start} = 4'h4;
      #3000;
      $display("done relay strap %0d", strap);
   endtask

   // Serial clock of 48 ns runs only inside the frame
   task automatic spi_read(input logic [7:0] addr, input int nbytes, output logic [31:0] data);
      data = 32'h0;
      @(posedge sys_clk);
      #1 host_port_cs_b = 1'b0;
      #100;
      for (int i = 0; i < 8; i++) begin
         host_port_serial_in = addr[7-i];
         #24 host_port_sclk = 1'b1;
         #24 host_port_sclk = 1'b0;
      end
      check("oe_in_frame", host_port_serial_out_oe, 1'b1);
      for (int i = 0; i < nbytes * 8; i++) begin
         #24 data = {data[30:0], host_port_serial_out};
         host_port_sclk = 1'b1;
         #24 host_port_sclk = 1'b0;
      end
      #50 host_port_cs_b = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 check("oe_released", host_port_serial_out_oe, 1'b0);
      #3000;
   endtask

   task automatic scan(input logic gsrc);
      int n;
      @(posedge sys_clk);
      #1 general_analog_input_src = gsrc;
      conv_req = 1'b1;
      @(posedge sys_clk);
      #1 conv_req = 1'b0;
      for (int ch = 0; ch < 9; ch++) begin
         n = 0;
         while (adc_sample !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
         end
         check("mux_sel", adc_mux_sel, ch);
         check("busy", conv_busy, 1'b1);
         if (ch == 0) check("general_analog_input_path", adc_general_analog_input_path, gsrc);
         repeat (2) @(posedge sys_clk);
         #1 adc_done = 1'b1;
         adc_raw = raw_v[ch];
         @(posedge sys_clk);
         #1 adc_done = 1'b0;
      end
      @(posedge sys_clk);
      #1 check("idle", conv_busy, 1'b0);
      $display("done scan source %0d", gsrc);
   endtask

   task automatic fault_chk(input int steps);
      int n;
      n = 0;
      fault_delay_steps = steps[4:0];
      @(posedge sys_clk);
      #1 fault_in = 1'b1;
      while (fault_qualified !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("fault_early", n >= (steps - 1) * 8, 1);
      check("fault_late", n <= steps * 8 + 4, 1);
      fault_in = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check("fault_drop", fault_qualified, 1'b0);
      $display("done fault steps %0d", steps);
   endtask

   task automatic otp_chk();
      int n;
      n = 0;
      @(posedge sys_clk);
      #1 otp_write_req = 1'b1;
      @(posedge sys_clk);
      #1 otp_write_req = 1'b0;
      check("otp_start", otp_busy, 1'b1);
      while (otp_busy === 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("otp_len", n, 20);
      $display("done otp pulse");
   endtask

   initial begin
      rst_b = 1'b0;
      stack_strap = 1'b0;
      {host_port_sclk, host_port_cs_b, host_port_serial_in, host_port_convert_start} = 4'h4;
      {south_port_sclk, south_port_cs_b, south_port_serial_in, south_port_convert_start} = 4'h4;
      conv_req = 1'b0;
      general_analog_input_src = 1'b0;
      adc_done = 1'b0;
      adc_raw = 16'sh0000;
      fault_in = 1'b0;
      fault_delay_steps = 5'h01;
      otp_write_req = 1'b0;
      model_want = 4'h0;
      do_reset(1'b0);
      relay_chk(1'b0);
      raw_v = '{16'sh0123, 16'sh224d, 16'sh7fff, -16'sh0010, 16'sh0004, 16'sh0005,
         16'sh0006, 16'sh0007, 16'sh0008};
      scan(1'b1);
      spi_read(8'h03, 4, d);
      check("cell1_pair", d, 32'h224d3fff);
      spi_read(8'h07, 2, d);
      check("clamp_low", d, 32'h00000000);
      spi_read(8'h01, 2, d);
      check("general_analog_input_pair", d, 32'h00000123);
      @(posedge sys_clk);
      #1 adc_done = 1'b1;
      adc_raw = 16'sh1111;
      @(posedge sys_clk);
      #1 adc_done = 1'b0;
      spi_read(8'h03, 2, d);
      check("held_pair", d, 32'h0000224d);
      spi_read(8'h13, 1, d);
      check("unmapped", d, 32'h00000000);
      raw_v[1] = -16'sh0001;
      raw_v[2] = 16'sh3fff;
      scan(1'b0);
      spi_read(8'h03, 4, d);
      check("cell1_new", d, 32'h00003fff);
      fault_chk(1);
      fault_chk(3);
      otp_chk();
      do_reset(1'b1);
      relay_chk(1'b1);
      summarize();
   end

   initial begin
      #200000;
      error_cnt++;
      $display("watchdog expired");
      summarize();
   end
endmodule
`default_nettype wire
